// ### logic/uphy_fifo.sv
// synchronous valid/ready fifo
`timescale 1ns/100ps
module uphy_fifo #(
  parameter int W = 17,
  parameter int D = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // fill side
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  // honest full and empty from the word count
  assign o_in_ready = (cnt_q != (AW+1)'(D));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem[rd_q];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // storage
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_q] <= i_in_data;
    end
  end

  // pointers and count
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // uphy_fifo

// ### logic/uphy_pin_sync.sv
// three-stage pin synchroniser with agreement of stages two and three
`timescale 1ns/100ps
module uphy_pin_sync #(
  parameter int W = 5
) (
  // clock
  input wire logic i_clk,
  // pins and result
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // no reset: stages keep sampling during reset so straps are valid at
  // the release edge
  always_ff @(posedge i_clk) begin
    s1_q <= i_pin;
    s2_q <= s1_q;
    s3_q <= s2_q;
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge i_clk) begin
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        o_level[i] <= s3_q[i];
      end
    end
  end
endmodule // uphy_pin_sync

// ### logic/uphy_pkg.sv
// shared constants and types of the parallel transceiver port
package uphy_pkg;

  // operational mode codes
  localparam logic [1:0] OP_NORMAL = 2'h0;
  localparam logic [1:0] OP_NODRIVE = 2'h1;
  localparam logic [1:0] OP_RAW = 2'h2;
  localparam logic [1:0] OP_RESERVED = 2'h3;

  // timing: clock period and high-speed bit time in picoseconds
  localparam int CLK_PS = 40000;
  localparam int HS_BIT_PS = 1000000 / 480;
  localparam int HS_SYNC_MIN_BT = 8;
  localparam int HS_SYNC_MAX_BT = 16;
  localparam int HS_SYNC_RAW =
    (HS_SYNC_MIN_BT * HS_BIT_PS + CLK_PS - 1) / CLK_PS;
  localparam int HS_SYNC_CYC = (HS_SYNC_RAW < 1) ? 1 : HS_SYNC_RAW;
  localparam int FS_SYNC_MIN_IFCLK = 1;
  localparam int FS_SYNC_MAX_IFCLK = 2;

  // reset values and transmit fifo depth
  localparam logic RST_WIDE = 1'b0;
  localparam logic RST_UNI = 1'b0;
  localparam int TX_FIFO_DEPTH = 16;

  // one transfer word with its upper-byte qualifier
  typedef struct packed {
    logic hi_valid;
    logic [15:0] data;
  } uphy_word_t;

  // synchronised configuration pins
  typedef struct packed {
    logic [1:0] op;
    logic speed;
    logic wide;
    logic uni;
  } uphy_mode_t;

endpackage

// ### logic/uphy_port.sv
// parallel link-side port of a usb 2.0 hs/fs transceiver
// Operation
// - mode 00 normal, 01 non-driving, 10 no stuffing/nrzi, 11 reserved
// - request rising starts sync; request falling starts end of packet
// - high speed: sync 8 to 16 bit times after request seen; here one 40 ns clock, about 19 bit times
// - full speed: sync one to two interface clocks after request seen
// - request with accept at an edge loads holding register next edge
// - receive-present while holding register full; engine latches then
// - in-packet set on sync, cleared on stuff error or end of packet
// - receive fault is 1 on detected error, 0 otherwise; here it holds 1 until the next sync
// - wide bus, request low: qualifier is output for upper rx byte
// - narrow bus: qualifier undefined; low byte qualified by present
// - width select 1 gives 16-bit at 30 MHz, 0 gives 8-bit at 60 MHz; here the strobe is every 40 ns clock narrow, every second clock wide
// - narrow bidi upper byte undefined; uni: low rx, upper tx
// - width select sampled only at end of reset, later changes ignored
// - active-high reset returns everything to initial state
// - speed select 0 high speed, 1 full speed; picks sync timing
// - interface clock is an output timing all data transfers
// - direction select high gives unidirectional narrow bus; static
`timescale 1ns/100ps
module uphy_port (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // configuration pins
  input wire logic i_op_select_hi,
  input wire logic i_op_select_lo,
  input wire logic i_speed_select,
  input wire logic i_bus_width_select,
  input wire logic i_uni_select,
  // engine transmit side
  input wire logic i_transmit_request,
  output logic o_transmit_accept,
  // engine data bus and qualifier pins
  input wire logic [15:0] i_data,
  output logic [15:0] o_data,
  output logic [1:0] o_data_oe,
  input wire logic i_upper_byte_qualifier,
  output logic o_upper_byte_qualifier,
  output logic o_upper_byte_qualifier_oe,
  // engine receive status and interface clock
  output logic o_receive_byte_present,
  output logic o_receive_in_packet,
  output logic o_receive_fault,
  output logic o_if_clk,
  // line transmit side
  output logic o_line_tx_valid,
  output uphy_pkg::uphy_word_t o_line_tx_word,
  input wire logic i_line_tx_ready,
  output logic o_line_sync_start,
  output logic o_line_eop_start,
  output logic o_line_drive,
  output logic o_line_stuff_bypass,
  // line receive side
  input wire logic i_line_rx_valid,
  input wire uphy_pkg::uphy_word_t i_line_rx_word,
  input wire logic i_line_sync_det,
  input wire logic i_line_eop_det,
  input wire logic i_line_stuff_err,
  input wire logic i_line_rx_err
);
  import uphy_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT = 4'h2,
    ST_DATA = 4'h4,
    ST_EOP = 4'h8
  } uphy_tx_st_t;

  uphy_tx_st_t st_q;
  uphy_mode_t pins;
  uphy_mode_t mode;
  logic wide_q;
  logic uni_q;
  logic strap_take_q;
  logic req_q;
  logic [3:0] cnt_q;
  logic pend_q;
  logic hold_full_q;
  uphy_word_t hold_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  uphy_word_t fifo_out;
  logic fifo_pop;
  logic rx_full_q;
  uphy_word_t rx_q;
  logic detect;
  logic accepted;
  logic x_next;
  logic hs;

  // capture of the transmit byte by bus configuration
  function automatic uphy_word_t take_word(input logic wide,
      input logic uni, input logic [15:0] d, input logic qual);
    uphy_word_t w;
    w = '0;
    if (wide) begin
      w.data = d;
      w.hi_valid = qual;
    end else begin
      w.data = {8'h00, uni ? d[15:8] : d[7:0]};
    end
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pins and straps

  // configuration pins come from outside the clock domain
  uphy_pin_sync #(
    .W(5)
  ) u_sync (
    .i_clk(i_clk),
    .i_pin({i_op_select_hi, i_op_select_lo, i_speed_select,
            i_bus_width_select, i_uni_select}),
    .o_level(pins)
  );

  // mode pins are live; width and direction are frozen straps
  always_comb begin
    mode = pins;
    mode.wide = wide_q;
    mode.uni = uni_q;
  end
  assign hs = ~mode.speed;

  // width and direction taken once, on the edge after reset release
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      strap_take_q <= 1'b1;
      wide_q <= RST_WIDE;
      uni_q <= RST_UNI;
    end else if (strap_take_q) begin
      strap_take_q <= 1'b0;
      wide_q <= pins.wide;
      uni_q <= pins.uni;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interface clock strobe

  // wide bus runs at half the narrow rate
  assign x_next = mode.wide ? ~o_if_clk : 1'b1;

  // transfers happen only in cycles where the strobe is high
  always_ff @(posedge i_clk) begin
    if (i_srst || strap_take_q) begin
      o_if_clk <= 1'b0;
    end else begin
      o_if_clk <= x_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line mode controls

  // reserved code behaves as normal operation
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_line_drive <= 1'b0;
      o_line_stuff_bypass <= 1'b0;
    end else begin
      o_line_drive <= (mode.op != OP_NODRIVE);
      o_line_stuff_bypass <= (mode.op == OP_RAW);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit state machine

  assign detect = (st_q == ST_IDLE) && i_transmit_request && !req_q;
  assign accepted = i_transmit_request && o_transmit_accept;

  // request history for edge detection
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      req_q <= 1'b0;
    end else begin
      req_q <= i_transmit_request;
    end
  end

  // sync on request rise, end of packet after request fall and drain
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      o_line_sync_start <= 1'b0;
      o_line_eop_start <= 1'b0;
    end else begin
      o_line_sync_start <= 1'b0;
      o_line_eop_start <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (detect) begin
            st_q <= ST_WAIT;
            cnt_q <= 4'(HS_SYNC_CYC - 1);
          end
        end
        ST_WAIT: begin
          if (hs ? (cnt_q == '0) : x_next) begin
            o_line_sync_start <= 1'b1;
            st_q <= ST_DATA;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        ST_DATA: begin
          if (!i_transmit_request) begin
            st_q <= ST_EOP;
          end
        end
        ST_EOP: begin
          if (!pend_q && !hold_full_q && !fifo_out_valid &&
              !o_line_tx_valid) begin
            o_line_eop_start <= 1'b1;
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // accept offered on a strobe when a word can be held
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_transmit_accept <= 1'b0;
    end else begin
      o_transmit_accept <= (st_q == ST_DATA) && i_transmit_request &&
        !accepted && !pend_q && !hold_full_q && x_next;
    end
  end

  // handshake edge arms the load; data is taken on the next edge
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      pend_q <= 1'b0;
      hold_full_q <= 1'b0;
      hold_q <= '0;
    end else begin
      pend_q <= accepted;
      if (pend_q) begin
        hold_q <= take_word(mode.wide, mode.uni, i_data,
                            i_upper_byte_qualifier);
        hold_full_q <= 1'b1;
      end else if (hold_full_q && fifo_in_ready) begin
        hold_full_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit buffer toward the serialiser

  uphy_fifo #(
    .W($bits(uphy_word_t)),
    .D(TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_in_valid(hold_full_q),
    .i_in_data(hold_q),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out),
    .i_out_ready(fifo_pop)
  );

  assign fifo_pop = !o_line_tx_valid || i_line_tx_ready;

  // registered output stage; serialiser stall backs up the fifo
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_line_tx_valid <= 1'b0;
      o_line_tx_word <= '0;
    end else if (fifo_pop) begin
      o_line_tx_valid <= fifo_out_valid;
      o_line_tx_word <= fifo_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive side

  // packet window and fault level; an end of packet wins over a sync
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_receive_in_packet <= 1'b0;
      o_receive_fault <= 1'b0;
    end else begin
      if (i_line_eop_det || i_line_stuff_err) begin
        o_receive_in_packet <= 1'b0;
      end else if (i_line_sync_det) begin
        o_receive_in_packet <= 1'b1;
      end
      if (i_line_rx_err || i_line_stuff_err) begin
        o_receive_fault <= 1'b1;
      end else if (i_line_sync_det) begin
        o_receive_fault <= 1'b0;
      end
    end
  end

  // holding register; a new word wins over the unload
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      rx_full_q <= 1'b0;
      rx_q <= '0;
    end else if (i_line_rx_valid && o_receive_in_packet) begin
      rx_full_q <= 1'b1;
      rx_q <= i_line_rx_word;
    end else if (o_receive_byte_present) begin
      rx_full_q <= 1'b0;
    end
  end

  // present for one strobe while the holding register is full
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_receive_byte_present <= 1'b0;
      o_data <= '0;
      o_upper_byte_qualifier <= 1'b0;
    end else begin
      o_receive_byte_present <= rx_full_q && x_next &&
        !o_receive_byte_present;
      if (rx_full_q && x_next && !o_receive_byte_present) begin
        o_data <= mode.wide ? rx_q.data : {8'h00, rx_q.data[7:0]};
        o_upper_byte_qualifier <= mode.wide && rx_q.hi_valid;
      end
    end
  end

  // bus direction: engine owns the bus while requesting, except the low byte in narrow uni mode
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_data_oe <= 2'h0;
      o_upper_byte_qualifier_oe <= 1'b0;
    end else begin
      o_data_oe[0] <= (!mode.wide && mode.uni) || !i_transmit_request;
      o_data_oe[1] <= mode.wide && !i_transmit_request;
      o_upper_byte_qualifier_oe <= mode.wide &&
        !i_transmit_request;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_raw_mode;
    @(posedge i_clk) disable iff (i_srst)
    (mode.op == OP_RAW) |=> o_line_stuff_bypass && o_line_drive;
  endproperty
  a_raw_mode: assert property (p_raw_mode)
    else $error("raw mode not applied");

  property p_nodrive;
    @(posedge i_clk) disable iff (i_srst)
    (mode.op == OP_NODRIVE) |=> !o_line_drive;
  endproperty
  a_nodrive: assert property (p_nodrive)
    else $error("line driven in non-driving mode");

  property p_hs_sync;
    @(posedge i_clk) disable iff (i_srst)
    (detect && hs) |-> ##2 o_line_sync_start;
  endproperty
  a_hs_sync: assert property (p_hs_sync)
    else $error("high-speed sync not at expected cycle");

  property p_fs_sync;
    @(posedge i_clk) disable iff (i_srst)
    (detect && !hs) |-> ##[2:3] o_line_sync_start;
  endproperty
  a_fs_sync: assert property (p_fs_sync)
    else $error("full-speed sync late");

  property p_load;
    @(posedge i_clk) disable iff (i_srst)
    accepted |=> ##1 (hold_full_q && hold_q.data ==
      take_word(mode.wide, mode.uni, $past(i_data), 1'b0).data);
  endproperty
  a_load: assert property (p_load)
    else $error("holding register not loaded after handshake");

  property p_active_clear;
    @(posedge i_clk) disable iff (i_srst)
    (i_line_eop_det || i_line_stuff_err) |=> !o_receive_in_packet;
  endproperty
  a_active_clear: assert property (p_active_clear)
    else $error("in-packet not cleared");

  property p_fault;
    @(posedge i_clk) disable iff (i_srst)
    i_line_rx_err |=> o_receive_fault;
  endproperty
  a_fault: assert property (p_fault)
    else $error("receive fault not raised");

  property p_qual_dir;
    @(posedge i_clk) disable iff (i_srst)
    1'b1 |=> o_upper_byte_qualifier_oe ==
      $past(mode.wide && !i_transmit_request);
  endproperty
  a_qual_dir: assert property (p_qual_dir)
    else $error("qualifier direction wrong");

  property p_strap;
    @(posedge i_clk) disable iff (i_srst)
    !strap_take_q |=> $stable(wide_q) && $stable(uni_q);
  endproperty
  a_strap: assert property (p_strap)
    else $error("width strap changed after reset");

  property p_present;
    @(posedge i_clk) disable iff (i_srst)
    o_receive_byte_present |-> o_if_clk && $past(rx_full_q);
  endproperty
  a_present: assert property (p_present)
    else $error("present without held word or off strobe");
endmodule // uphy_port

// ### testbench/tb.sv
// self-checking bench of the parallel transceiver port
`timescale 1ns/100ps
`define CHK(a, e, m) begin cmp_count++; if ((a) !== (e)) begin \
  n_mismatch++; $display("Error %0t: %s", $time, m); end end
module tb;
  import uphy_pkg::*;
  logic clk, srst, op_hi, op_lo, speed, wide, uni, line_ready, rx_valid;
  logic start, accept, present, in_pkt, fault, if_clk, ltx_valid, sync_s;
  logic eop_s, drive, bypass, qual_o, qual_oe, req, mqual, a;
  logic [3:0] ev;
  logic [7:0] count, sent, rx_cnt, rc;
  logic [15:0] base, dout, mdata, rx_last;
  logic [1:0] oe;
  uphy_word_t rx_word, ltx_word;
  logic [16:0] got[$];
  int n_mismatch, cmp_count, eop_n, eop_at;
  // falling edges from request rise to the sync pulse, per speed
  localparam int HS_K = HS_SYNC_CYC + 1;
  localparam int FS_LO = FS_SYNC_MIN_IFCLK + 1;
  localparam int FS_HI = FS_SYNC_MAX_IFCLK + 1;

  uphy_port u_uphy_port (
    .i_clk(clk), .i_srst(srst), .i_op_select_hi(op_hi),
    .i_op_select_lo(op_lo), .i_speed_select(speed),
    .i_bus_width_select(wide), .i_uni_select(uni),
    .i_transmit_request(req), .o_transmit_accept(accept),
    .i_data(mdata), .o_data(dout), .o_data_oe(oe),
    .i_upper_byte_qualifier(mqual), .o_upper_byte_qualifier(qual_o),
    .o_upper_byte_qualifier_oe(qual_oe), .o_receive_byte_present(present),
    .o_receive_in_packet(in_pkt), .o_receive_fault(fault),
    .o_if_clk(if_clk), .o_line_tx_valid(ltx_valid),
    .o_line_tx_word(ltx_word), .i_line_tx_ready(line_ready),
    .o_line_sync_start(sync_s), .o_line_eop_start(eop_s),
    .o_line_drive(drive), .o_line_stuff_bypass(bypass),
    .i_line_rx_valid(rx_valid), .i_line_rx_word(rx_word),
    .i_line_sync_det(ev[0]), .i_line_eop_det(ev[1]),
    .i_line_stuff_err(ev[2]), .i_line_rx_err(ev[3])
  );

  uphy_engine_model u_uphy_engine_model (
    .i_clk(clk), .i_srst(srst), .i_start(start), .i_count(count),
    .i_base(base), .i_accept(accept), .i_present(present),
    .i_rx_data(dout), .o_req(req), .o_data(mdata), .o_qual(mqual),
    .o_sent(sent), .o_rx_last(rx_last), .o_rx_cnt(rx_cnt)
  );

  //////////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #200000;
    n_mismatch++;
    $display("Error %0t: watchdog expired", $time);
    conclude();
  end

  // collect serialiser words and end-of-packet strobes
  always @(posedge clk) begin
    if (ltx_valid && line_ready) got.push_back(ltx_word);
    if (eop_s) begin
      eop_n++;
      eop_at = got.size();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // straps lead reset by one edge so the synchroniser holds them at release
  task do_reset(input logic w, input logic u);
    wide = w;
    uni = u;
    @(negedge clk);
    srst = 1'b1;
    repeat (2) @(negedge clk);
    `CHK({present, in_pkt, fault, accept}, 4'h0, "reset")
    `CHK({sync_s, eop_s, drive, ltx_valid}, 4'h0, "reset")
    @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    got.delete();
    eop_n = 0;
  endtask

  // one transmit packet of n words; sh moves the expected bus byte down
  task send(input int n, input logic [15:0] b, input logic stall,
            input int lo, input int hi, input logic [16:0] mask,
            input int sh);
    int k;
    logic [16:0] ew;
    count = n[7:0];
    base = b;
    line_ready = !stall;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    k = 0;
    while (!sync_s && k < 8) begin
      @(negedge clk);
      k++;
    end
    `CHK(k >= lo && k <= hi, 1'b1, "sync delay")
    if (stall) begin
      repeat (100) @(negedge clk);
      `CHK(sent >= 8'h10 && sent < count, 1'b1, "fill level")
      `CHK(accept, 1'b0, "accept while full")
      line_ready = 1'b1;
    end
    k = 0;
    while ((req || eop_n == 0) && k < 300) begin
      @(negedge clk);
      k++;
    end
    `CHK(eop_n == 1 && eop_at == n, 1'b1, "end of packet")
    `CHK(got.size() == n, 1'b1, "word count")
    for (int j = 0; j < got.size(); j++) begin
      ew = ({1'b1, b + j[15:0]} >> sh) & mask;
      `CHK(got[j] & mask, ew, "tx word")
    end
    got.delete();
    eop_n = 0;
  endtask

  // one-cycle line event: bit0 sync, bit1 eop, bit2 stuff, bit3 error
  task ev_pulse(input logic [3:0] v);
    ev = v;
    @(negedge clk);
    ev = 4'h0;
    @(negedge clk);
  endtask

  // one received word and the strobe that hands it to the engine
  task rx(input uphy_word_t w, input logic [15:0] ed, input logic eq);
    int k;
    rx_word = w;
    rx_valid = 1'b1;
    @(negedge clk);
    rx_valid = 1'b0;
    rx_word = ~w;
    k = 0;
    while (!present && k < 5) begin
      @(negedge clk);
      k++;
    end
    `CHK(present, 1'b1, "receive strobe")
    `CHK(dout, ed, "receive data")
    `CHK(qual_o, eq, "upper qualifier")
    @(negedge clk);
    `CHK(rx_last, ed, "engine latch")
  endtask

  task conclude();
    $display("counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    srst = 1'b0; op_hi = 1'b0; op_lo = 1'b0; speed = 1'b0; wide = 1'b0;
    uni = 1'b0; line_ready = 1'b1; rx_valid = 1'b0; rx_word = '0;
    ev = 4'h0; start = 1'b0; count = 8'h00; base = 16'h0000;
    n_mismatch = 0; cmp_count = 0;
    do_reset(1'b0, 1'b0);
    `CHK(if_clk, 1'b1, "narrow strobe")
    for (int m = 0; m < 3; m++) begin
      {op_hi, op_lo} = m[1:0];
      repeat (6) @(negedge clk);
      `CHK(drive, m != 1, "line drive")
      `CHK(bypass, m == 2, "stuff bypass")
    end
    {op_hi, op_lo} = 2'h0;
    repeat (6) @(negedge clk);
    send(3, 16'h0011, 1'b0, HS_K, HS_K, 17'h000ff, 0);
    speed = 1'b1;
    repeat (6) @(negedge clk);
    send(2, 16'h00a0, 1'b0, FS_LO, FS_HI, 17'h000ff, 0);
    speed = 1'b0;
    repeat (6) @(negedge clk);
    send(24, 16'h0040, 1'b1, HS_K, HS_K, 17'h000ff, 0);
    $display("test done: modes and transmit");
    rc = rx_cnt;
    rx_valid = 1'b1;
    @(negedge clk);
    rx_valid = 1'b0;
    repeat (5) @(negedge clk);
    `CHK(rx_cnt, rc, "word outside packet")
    ev_pulse(4'h1);
    `CHK(in_pkt, 1'b1, "in packet")
    rx({1'b0, 16'h3c5a}, 16'h005a, 1'b0);
    ev_pulse(4'h2);
    `CHK({in_pkt, fault}, 2'h0, "eop")
    ev_pulse(4'h1);
    ev_pulse(4'h4);
    `CHK({in_pkt, fault}, 2'h1, "stuff error")
    ev_pulse(4'h1);
    `CHK(fault, 1'b0, "fault cleared")
    ev_pulse(4'h8);
    `CHK(fault, 1'b1, "receive fault")
    ev_pulse(4'h2);
    $display("test done: receive");
    do_reset(1'b0, 1'b1);
    `CHK(oe, 2'h1, "uni enables")
    send(2, 16'h12ff, 1'b0, HS_K, HS_K, 17'h000ff, 8);
    do_reset(1'b1, 1'b0);
    a = if_clk;
    @(negedge clk);
    `CHK(if_clk, ~a, "wide strobe")
    `CHK(qual_oe, 1'b1, "qualifier output")
    wide = 1'b0;
    repeat (4) @(negedge clk);
    a = if_clk;
    @(negedge clk);
    `CHK(if_clk, ~a, "width held")
    send(2, 16'hc35a, 1'b0, HS_K, HS_K, 17'h1ffff, 0);
    ev_pulse(4'h1);
    rx({1'b1, 16'hbeef}, 16'hbeef, 1'b1);
    ev_pulse(4'h2);
    $display("test done: wide bus");
    conclude();
  end
endmodule // tb

// ### testbench/uphy_engine_model.sv
// behavioural protocol engine facing the port's data bus
`timescale 1ns/100ps
module uphy_engine_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // packet command from the bench
  input wire logic i_start,
  input wire logic [7:0] i_count,
  input wire logic [15:0] i_base,
  // port side
  input wire logic i_accept,
  input wire logic i_present,
  input wire logic [15:0] i_rx_data,
  output logic o_req,
  output logic [15:0] o_data,
  output logic o_qual,
  // progress seen by the bench
  output logic [7:0] o_sent,
  output logic [15:0] o_rx_last,
  output logic [7:0] o_rx_cnt
);
  logic start_q;
  logic [1:0] took_q;

  //////////////////////////////////////////////////////////////////////////
  // sample the port's answers on the rising edge
  always @(posedge i_clk) begin
    start_q <= i_start;
    took_q <= {took_q[0], o_req & i_accept};
    if (i_srst) begin
      o_rx_cnt <= 8'h00;
    end else if (i_present) begin
      o_rx_last <= i_rx_data;
      o_rx_cnt <= o_rx_cnt + 8'h01;
    end
  end

  // drive request and words off the falling edge
  always @(negedge i_clk) begin
    if (i_srst) begin
      o_req <= 1'b0;
      o_sent <= 8'h00;
      o_data <= 16'h5a5a;
      o_qual <= 1'b0;
    end else if (!o_req && start_q) begin
      o_req <= 1'b1;
      o_sent <= 8'h00;
      o_data <= i_base;
      o_qual <= 1'b1;
    end else if (o_req && took_q[1]) begin
      // word loaded one edge after the handshake: present the next
      o_sent <= o_sent + 8'h01;
      o_data <= i_base + {8'h00, o_sent} + 16'h0001;
      o_req <= (o_sent + 8'h01 != i_count);
    end else if (!o_req) begin
      // released bus never keeps its last value
      o_data <= ~o_data;
      o_qual <= ~o_qual;
    end
  end
endmodule // uphy_engine_model
